// ---- src/bxe_pkg.sv ----
package bxe_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 15;
    localparam int BRANCH_W = 11;
    localparam int FADDR_W = 7;
    localparam int LATCH_W = 7;
    // Latch bits [6:3] feed counter bits [14:11].
    localparam int LATCH_HI = 6;
    localparam int LATCH_LO = 3;
    localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic DEST_ACC = 1'b0;

    typedef enum logic [2:0]
    {
        BXE_OP_NONE,
        BXE_OP_BRANCH,
        BXE_OP_INC,
        BXE_OP_INC_SKIP,
        BXE_OP_OR_LIT,
        BXE_OP_OR_REG,
        BXE_OP_SHL,
        BXE_OP_SHR
    } bxe_op_t;
endpackage : bxe_pkg

// ---- src/bxe_alu_if.sv ----
interface bxe_alu_if;
    import bxe_pkg::*;
    bxe_op_t op;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] file_value;
    logic [DATA_W-1:0] literal;
    logic [DATA_W-1:0] result;
    logic shift_out;
    logic is_zero;

    modport core (output op, output acc, output file_value, output literal,
        input result, input shift_out, input is_zero);
    modport alu (input op, input acc, input file_value, input literal,
        output result, output shift_out, output is_zero);
endinterface : bxe_alu_if

// ---- src/bxe_alu.sv ----
module bxe_alu
(
    bxe_alu_if.alu alu
);
    import bxe_pkg::*;

    always_comb
    begin
        alu.shift_out = 1'b0;
        case (alu.op)
            BXE_OP_INC, BXE_OP_INC_SKIP:
                alu.result = alu.file_value + DATA_ONE;
            BXE_OP_OR_LIT:
                alu.result = alu.acc | alu.literal;
            BXE_OP_OR_REG:
                alu.result = alu.acc | alu.file_value;
            BXE_OP_SHL:
            begin
                alu.shift_out = alu.file_value[DATA_W-1];
                alu.result = {alu.file_value[DATA_W-2:0], 1'b0};
            end
            BXE_OP_SHR:
            begin
                alu.shift_out = alu.file_value[0];
                alu.result = {1'b0, alu.file_value[DATA_W-1:1]};
            end
            default:
                alu.result = DATA_ZERO;
        endcase
        alu.is_zero = (alu.result == DATA_ZERO);
    end
endmodule : bxe_alu

// ---- src/bxe_exec.sv ----
// What this block does
// - Branch loads 11-bit immediate into counter [10:0]; flags unchanged.
// - Branch fills counter [14:11] from high latch bits [6:3].
// - Branch takes two instruction cycles, second flushes the pipeline.
// - Destination bit 0 writes accumulator, 1 writes file register; OR literal always writes accumulator.
// - Increment adds one to the file register and updates zero.
// - Increment-skip with zero result replaces next instruction by a nop.
// - Increment-skip with nonzero result continues and changes no flag.
// - OR literal ORs accumulator with 8-bit immediate, updates zero.
// - OR register ORs accumulator with file, routes result, updates zero.
// - Left shift moves bit 7 to shift-out, zero into bit 0.
// - Right shift moves bit 0 to shift-out, zero into bit 7.
module bxe_exec
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire bxe_pkg::bxe_op_t instr_op,
    input wire logic [bxe_pkg::BRANCH_W-1:0] instr_imm,
    input wire logic [bxe_pkg::FADDR_W-1:0] instr_faddr,
    input wire logic instr_dest,
    input wire logic [bxe_pkg::LATCH_W-1:0] program_counter_high_latch,
    input wire logic [bxe_pkg::DATA_W-1:0] file_rdata,
    output logic [bxe_pkg::PC_W-1:0] pc,
    output logic [bxe_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic shift_out_flag,
    output logic file_we,
    output logic [bxe_pkg::FADDR_W-1:0] file_waddr,
    output logic [bxe_pkg::DATA_W-1:0] file_wdata,
    output logic flush,
    output logic busy
);
    import bxe_pkg::*;

    typedef enum logic
    {
        BXE_RUN,
        BXE_STALL
    } bxe_state_t;

    typedef struct packed
    {
        bxe_state_t state;
        logic [PC_W-1:0] pc;
        logic [DATA_W-1:0] acc;
        logic zero_flag;
        logic shift_out_flag;
        logic file_we;
        logic [FADDR_W-1:0] file_waddr;
        logic [DATA_W-1:0] file_wdata;
        logic flush;
        logic busy;
    } bxe_regs_t;

    bxe_regs_t r;
    bxe_regs_t next_r;
    bxe_alu_if alu_bus ();

    bxe_alu u_alu
    (
        .alu(alu_bus)
    );

    // Writes result to the accumulator or the file register per dest.
    function automatic bxe_regs_t route_result(input bxe_regs_t s,
        input logic dest, input logic [FADDR_W-1:0] addr,
        input logic [DATA_W-1:0] value);
        bxe_regs_t o;
        o = s;
        if (dest == DEST_ACC)
        begin
            o.acc = value;
        end
        else
        begin
            o.file_we = 1'b1;
            o.file_waddr = addr;
            o.file_wdata = value;
        end
        return o;
    endfunction : route_result

    // Next counter value; a taken skip steps over the dropped successor.
    function automatic logic [PC_W-1:0] step_pc(input logic [PC_W-1:0] p,
        input logic skip);
        logic [PC_W-1:0] n;
        n = p + PC_STEP;
        if (skip)
        begin
            n = n + PC_STEP;
        end
        return n;
    endfunction : step_pc

    // The latch supplies the page bits above the 11-bit immediate.
    function automatic logic [PC_W-1:0] branch_target(
        input logic [LATCH_W-1:0] latch, input logic [BRANCH_W-1:0] imm);
        return {latch[LATCH_HI:LATCH_LO], imm};
    endfunction : branch_target

    assign alu_bus.op = instr_op;
    assign alu_bus.acc = r.acc;
    assign alu_bus.file_value = file_rdata;
    assign alu_bus.literal = instr_imm[DATA_W-1:0];

    always_comb
    begin
        next_r = r;
        next_r.file_we = 1'b0;
        next_r.flush = 1'b0;
        case (r.state)
            BXE_RUN:
            begin
                if (instr_valid)
                begin
                    case (instr_op)
                        BXE_OP_NONE:
                        begin
                            // An empty slot leaves the counter where it is.
                            next_r.pc = r.pc;
                        end
                        BXE_OP_BRANCH:
                        begin
                            // Flags are left alone on purpose.
                            next_r.pc = branch_target(
                                program_counter_high_latch, instr_imm);
                            next_r.flush = 1'b1;
                            next_r.state = BXE_STALL;
                        end
                        BXE_OP_INC_SKIP:
                        begin
                            next_r = route_result(next_r, instr_dest,
                                instr_faddr, alu_bus.result);
                            next_r.pc = step_pc(r.pc,
                                alu_bus.is_zero);
                            if (alu_bus.is_zero)
                            begin
                                // The fetched successor is dropped as a nop.
                                next_r.flush = 1'b1;
                                next_r.state = BXE_STALL;
                            end
                            next_r.zero_flag = r.zero_flag;
                            next_r.shift_out_flag = r.shift_out_flag;
                        end
                        BXE_OP_INC:
                        begin
                            next_r = route_result(next_r, instr_dest,
                                instr_faddr, alu_bus.result);
                            next_r.zero_flag = alu_bus.is_zero;
                            next_r.pc = step_pc(r.pc, 1'b0);
                        end
                        BXE_OP_OR_REG:
                        begin
                            next_r = route_result(next_r, instr_dest,
                                instr_faddr, alu_bus.result);
                            next_r.zero_flag = alu_bus.is_zero;
                            next_r.pc = step_pc(r.pc, 1'b0);
                        end
                        BXE_OP_OR_LIT:
                        begin
                            // The destination bit is ignored here.
                            next_r.acc = alu_bus.result;
                            next_r.zero_flag = alu_bus.is_zero;
                            next_r.pc = step_pc(r.pc, 1'b0);
                        end
                        BXE_OP_SHL:
                        begin
                            next_r = route_result(next_r, instr_dest,
                                instr_faddr, alu_bus.result);
                            next_r.shift_out_flag =
                                alu_bus.shift_out;
                            next_r.zero_flag = alu_bus.is_zero;
                            next_r.pc = step_pc(r.pc, 1'b0);
                        end
                        BXE_OP_SHR:
                        begin
                            next_r = route_result(next_r, instr_dest,
                                instr_faddr, alu_bus.result);
                            next_r.shift_out_flag =
                                alu_bus.shift_out;
                            next_r.zero_flag = alu_bus.is_zero;
                            next_r.pc = step_pc(r.pc, 1'b0);
                        end
                        default:
                            next_r.pc = r.pc;
                    endcase
                end
            end
            BXE_STALL:
                // Second cycle: instruction input is ignored here.
                next_r.state = BXE_RUN;
            default:
                next_r.state = BXE_RUN;
        endcase
        // Busy is kept in a flop so the output carries no decode glitch.
        next_r.busy = (next_r.state == BXE_STALL);
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            r.state <= BXE_RUN;
            r.pc <= PC_RESET;
            r.acc <= DATA_RESET;
            r.zero_flag <= 1'b0;
            r.shift_out_flag <= 1'b0;
            r.file_we <= 1'b0;
            r.file_waddr <= '0;
            r.file_wdata <= DATA_RESET;
            r.flush <= 1'b0;
            r.busy <= 1'b0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign pc = r.pc;
    assign acc = r.acc;
    assign zero_flag = r.zero_flag;
    assign shift_out_flag = r.shift_out_flag;
    assign file_we = r.file_we;
    assign file_waddr = r.file_waddr;
    assign file_wdata = r.file_wdata;
    assign flush = r.flush;
    assign busy = r.busy;
endmodule : bxe_exec

// ---- testbench/bxe_exec_properties.sv ----
module bxe_exec_properties
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire bxe_pkg::bxe_op_t instr_op,
    input wire logic [10:0] instr_imm,
    input wire logic instr_dest,
    input wire logic [6:0] program_counter_high_latch,
    input wire logic [7:0] file_rdata,
    input wire logic [14:0] pc,
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic shift_out_flag,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic flush,
    input wire logic busy
);
    import bxe_pkg::*;
    wire t = instr_valid && !busy;
    wire [3:0] lat = program_counter_high_latch[6:3];
    wire [7:0] lit = instr_imm[7:0];
    wire msb = file_rdata[7];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_branch_load: assert property (
        t && instr_op == BXE_OP_BRANCH |=> flush && busy
        && pc == {$past(lat), $past(instr_imm)}) else $error("bad branch");
    a_busy_single: assert property (busy |=> !busy)
        else $error("busy too long");
    a_skip_null: assert property (
        t && instr_op == BXE_OP_INC_SKIP && file_rdata == 8'hFF |=> busy
        && flush && pc == $past(pc) + 15'h0002) else $error("bad skip");
    a_skip_flags: assert property (
        t && instr_op == BXE_OP_INC_SKIP |=> $stable(zero_flag)
        && $stable(shift_out_flag)) else $error("skip changed flags");
    a_inc_file: assert property (
        t && instr_op == BXE_OP_INC && instr_dest |=> file_we
        && file_wdata == $past(file_rdata) + 8'h01) else $error("bad inc");
    a_or_literal: assert property (
        t && instr_op == BXE_OP_OR_LIT |=> acc == ($past(acc) | $past(lit))
        && zero_flag == (acc == 8'h00)) else $error("bad or literal");
    a_shift_out: assert property (
        t && instr_op == BXE_OP_SHL |=> shift_out_flag == $past(msb))
        else $error("bad shift out");
    a_one_step: assert property (
        t && instr_op inside {BXE_OP_INC, BXE_OP_OR_REG, BXE_OP_SHR}
        |=> pc == $past(pc) + 15'h0001 && !busy) else $error("bad step");
endmodule : bxe_exec_properties

bind bxe_exec bxe_exec_properties i_bxe_exec_properties (.core_clk, .reset,
    .instr_valid, .instr_op, .instr_imm, .instr_dest, .file_rdata, .pc,
    .program_counter_high_latch, .acc, .zero_flag, .shift_out_flag,
    .file_we, .file_wdata, .flush, .busy);

// ---- testbench/tb_bxe_exec.sv ----
module tb_bxe_exec;
    timeunit 1ns;
    timeprecision 1ns;
    import bxe_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    bxe_op_t instr_op = BXE_OP_NONE;
    logic [10:0] instr_imm = 11'h000;
    logic [6:0] instr_faddr = 7'h00;
    logic instr_dest = 1'b0;
    logic [6:0] program_counter_high_latch = 7'h5F;
    logic [7:0] file_rdata = 8'h00;
    logic [14:0] pc;
    logic [7:0] acc, file_wdata;
    logic [6:0] file_waddr;
    logic zero_flag, shift_out_flag, file_we, flush, busy;
    int err_total = 0;
    int check_count = 0;
    always #50 core_clk = ~core_clk;
    bxe_exec i_bxe_exec (.core_clk, .reset, .instr_valid, .instr_op,
        .instr_imm, .instr_faddr, .instr_dest, .program_counter_high_latch,
        .file_rdata, .pc, .acc, .zero_flag, .shift_out_flag, .file_we,
        .file_waddr, .file_wdata, .flush, .busy);

    task automatic check(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // Valid drops at the taking edge, so each call spends two cycles.
    task automatic run(input bxe_op_t o, input logic [10:0] k,
        input logic d, input logic [7:0] r);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op <= o;
        instr_imm <= k;
        instr_faddr <= k[6:0];
        instr_dest <= d;
        file_rdata <= r;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #10;
    endtask : run

    task automatic t_or;
        run(BXE_OP_OR_LIT, 11'h700, 1'b1, 8'hFF);
        check("acc", acc, 16'h0000);
        check("zero", zero_flag, 16'h0001);
        check("we", file_we, 16'h0000);
        run(BXE_OP_OR_LIT, 11'h0A5, 1'b0, 8'h00);
        check("acc", acc, 16'h00A5);
        run(BXE_OP_OR_REG, 11'h000, 1'b1, 8'h5A);
        check("wdata", file_wdata, 16'h00FF);
        check("acc", acc, 16'h00A5);
        check("pc", pc, 16'h0003);
        $display("or test done");
    endtask : t_or

    task automatic t_branch;
        run(BXE_OP_INC, 11'h010, 1'b1, 8'hFF);
        check("zero", zero_flag, 16'h0001);
        run(BXE_OP_BRANCH, 11'h7FF, 1'b0, 8'h00);
        check("pc", pc, 16'h5FFF);
        check("busy", busy, 16'h0001);
        check("flush", flush, 16'h0001);
        check("zero", zero_flag, 16'h0001);
        $display("branch test done");
    endtask : t_branch

    // An increment offered in the busy cycle after a branch must be ignored.
    task automatic t_refuse;
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op <= BXE_OP_BRANCH;
        instr_imm <= 11'h123;
        instr_dest <= 1'b1;
        file_rdata <= 8'h7F;
        @(posedge core_clk);
        instr_op <= BXE_OP_INC;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #10;
        check("we", file_we, 16'h0000);
        check("busy", busy, 16'h0000);
        check("pc", pc, 16'h5923);
        run(BXE_OP_NONE, 11'h000, 1'b1, 8'h00);
        check("pc", pc, 16'h5923);
        check("we", file_we, 16'h0000);
        $display("refuse test done");
    endtask : t_refuse

    task automatic t_inc;
        run(BXE_OP_INC, 11'h07F, 1'b1, 8'hFF);
        check("waddr", file_waddr, 16'h007F);
        check("wdata", file_wdata, 16'h0000);
        check("zero", zero_flag, 16'h0001);
        run(BXE_OP_INC, 11'h005, 1'b0, 8'h41);
        check("we", file_we, 16'h0000);
        check("acc", acc, 16'h0042);
        run(BXE_OP_INC_SKIP, 11'h000, 1'b0, 8'hFF);
        check("flush", flush, 16'h0001);
        check("zero", zero_flag, 16'h0000);
        run(BXE_OP_INC_SKIP, 11'h000, 1'b1, 8'h0F);
        check("flush", flush, 16'h0000);
        check("pc", pc, 16'h6004);
        $display("increment test done");
    endtask : t_inc

    task automatic t_shift;
        run(BXE_OP_SHL, 11'h000, 1'b0, 8'h81);
        check("acc", acc, 16'h0002);
        check("carry", shift_out_flag, 16'h0001);
        run(BXE_OP_SHR, 11'h000, 1'b1, 8'h01);
        check("wdata", file_wdata, 16'h0000);
        check("carry", shift_out_flag, 16'h0001);
        check("zero", zero_flag, 16'h0001);
        $display("shift test done");
    endtask : t_shift

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #10;
        check("pc", pc, 16'h0000);
        check("busy", busy, 16'h0000);
        t_or();
        t_branch();
        t_inc();
        t_shift();
        t_refuse();
        finish_test();
    end
endmodule : tb_bxe_exec
